/* File: scsp_client.sv */
// SPI client end of the serial port with its APB register file
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ns

// Behaviour
// - Shift only on host clock; flag byte done
// - Host holds clock idle before enable
// - Keeps shifting in sleep; flag, optional wake
// - Host port freezes during sleep, resumes after
// - Overwrite enable stores every new byte
// - Retransmits received byte on next group
// - Select control only in mode 0100
// - Select low enables shifting and drives output
// - Select high releases output three clock cycles later
// - Select high or disable clears bit count
// - Edge select set needs select control
// - Software keeps sample phase clear
// - Host keeps select high until ready
// - MSb first; full byte sets full, done
// - Busy write collides; data read clears full
// - Edge select picks output change edge
module scsp_client (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // APB slave
    input wire logic [scsp_pkg::ADDR_W-1:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [scsp_pkg::DATA_W-1:0] pwdata_i,
    output logic [scsp_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Power and events
    input wire logic sleep_i,
    output logic irq_o,
    output logic wake_o,
    // Serial link
    scsp_if.client link
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic sck_m;
        logic sck_s;
        logic sck_p;
        logic ss_m;
        logic ss_s;
        logic mosi_m;
        logic mosi_s;
        logic [scsp_pkg::BYTE_W-1:0] sr;
        logic [scsp_pkg::BYTE_W-1:0] dbuf;
        logic [scsp_pkg::CNT_W-1:0] cnt;
        logic out;
        logic oe;
        logic [scsp_pkg::CTRL_W-1:0] ctrl;
        logic bf;
        logic done;
        logic write_collision_flag;
        logic ovf;
        logic [scsp_pkg::ST_W-1:0] mask;
        logic irq;
        logic wake;
        logic pready;
        logic pslverr;
        logic [scsp_pkg::DATA_W-1:0] prdata;
    } scsp_client_reg_type;

    scsp_client_reg_type q;
    scsp_client_reg_type d;

    logic en;
    logic use_ss;
    logic client;
    logic selected;
    logic clock_idle_polarity;
    logic cke;
    logic buffer_overwrite_enable;
    logic act;
    logic act_p;
    logic lead;
    logic trail;
    logic smp_e;
    logic sh_e;
    logic busy;
    logic setup;
    logic wr;
    logic rd;
    logic byte_done;
    logic [scsp_pkg::BYTE_W-1:0] rx;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [scsp_pkg::ST_W-1:0] stat_vec(
        input scsp_client_reg_type s,
        input logic b
    );
        stat_vec = '0;
        stat_vec[scsp_pkg::ST_BF] = s.bf;
        stat_vec[scsp_pkg::ST_DONE] = s.done;
        stat_vec[scsp_pkg::ST_WRITE_COLLISION_FLAG] = s.write_collision_flag;
        stat_vec[scsp_pkg::ST_OVF] = s.ovf;
        stat_vec[scsp_pkg::ST_BUSY] = b;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        // Two flops on every link input before any logic reads it
        d.sck_m = link.sck;
        d.sck_s = q.sck_m;
        d.sck_p = q.sck_s;
        d.ss_m = link.ss_n;
        d.ss_s = q.ss_m;
        d.mosi_m = link.mosi;
        d.mosi_s = q.mosi_m;

        en = q.ctrl[scsp_pkg::CTRL_EN];
        clock_idle_polarity = q.ctrl[scsp_pkg::CTRL_CKP];
        cke = q.ctrl[scsp_pkg::CTRL_CKE];
        buffer_overwrite_enable = q.ctrl[scsp_pkg::CTRL_BUFFER_OVERWRITE_ENABLE];
        use_ss = q.ctrl[scsp_pkg::CTRL_MODE +: scsp_pkg::MODE_W]
            == scsp_pkg::MODE_CLIENT_SS;
        client = en && (use_ss || q.ctrl[scsp_pkg::CTRL_MODE +: scsp_pkg::MODE_W]
            == scsp_pkg::MODE_CLIENT_FREE);
        selected = client && !(use_ss && q.ss_s);

        // Edges of the host clock, relative to its idle level
        act = q.sck_s ^ clock_idle_polarity;
        act_p = q.sck_p ^ clock_idle_polarity;
        lead = act && !act_p;
        trail = !act && act_p;
        smp_e = cke ? lead : trail;
        sh_e = cke ? trail : lead;
        busy = (q.cnt != '0) || (selected && smp_e);
        rx = {q.sr[scsp_pkg::BYTE_W-2:0], q.mosi_s};
        byte_done = 1'b0;

        // APB: one wait state, answer from flops
        setup = psel_i && penable_i && !q.pready;
        wr = psel_i && penable_i && q.pready && pwrite_i;
        rd = psel_i && penable_i && q.pready && !pwrite_i;
        d.pready = setup;
        d.pslverr = 1'b0;
        d.prdata = '0;
        if (setup) begin
            case (paddr_i)
                scsp_pkg::C_CTRL: d.prdata = scsp_pkg::DATA_W'(q.ctrl);
                scsp_pkg::C_STAT: d.prdata = scsp_pkg::DATA_W'(stat_vec(q, busy));
                scsp_pkg::C_MASK: d.prdata = scsp_pkg::DATA_W'(q.mask);
                scsp_pkg::C_DATA: d.prdata = scsp_pkg::DATA_W'(q.dbuf);
                default: d.pslverr = 1'b1;
            endcase
        end

        // Software clears go first so a same-cycle event wins
        if (wr && paddr_i == scsp_pkg::C_STAT) begin
            d.done = q.done && !pwdata_i[scsp_pkg::ST_DONE];
            d.write_collision_flag = q.write_collision_flag && !pwdata_i[scsp_pkg::ST_WRITE_COLLISION_FLAG];
            d.ovf = q.ovf && !pwdata_i[scsp_pkg::ST_OVF];
        end
        if (rd && paddr_i == scsp_pkg::C_DATA) begin
            d.bf = 1'b0;
        end
        if (wr && paddr_i == scsp_pkg::C_CTRL) begin
            d.ctrl = pwdata_i[scsp_pkg::CTRL_W-1:0];
        end
        if (wr && paddr_i == scsp_pkg::C_MASK) begin
            d.mask = pwdata_i[scsp_pkg::ST_W-1:0];
        end
        if (wr && paddr_i == scsp_pkg::C_DATA) begin
            // A pending collision must be cleared before writes land again
            if (busy || q.write_collision_flag) begin
                d.write_collision_flag = 1'b1;
            end else begin
                d.sr = pwdata_i[scsp_pkg::BYTE_W-1:0];
                d.dbuf = pwdata_i[scsp_pkg::BYTE_W-1:0];
            end
        end

        // Serial engine; not gated by sleep_i, it runs off the link clock
        if (!selected) begin
            d.cnt = '0;
        end else begin
            if (smp_e) begin
                d.sr = rx;
                d.cnt = q.cnt + 1'b1;
                byte_done = (q.cnt == scsp_pkg::CNT_LAST);
            end
            if (sh_e || (cke && q.cnt == '0 && !smp_e)) begin
                // Received byte goes out again in the next group
                d.out = q.sr[scsp_pkg::BYTE_W-1];
            end
        end
        d.oe = selected;

        // Byte complete; all inputs were already synchronised
        if (byte_done) begin
            if (!q.bf || buffer_overwrite_enable) begin
                d.dbuf = rx;
            end else begin
                d.ovf = 1'b1;
            end
            d.bf = 1'b1;
            d.done = 1'b1;
        end

        // Wake request lasts while the device sleeps
        if (!sleep_i) begin
            d.wake = 1'b0;
        end else if (byte_done && q.ctrl[scsp_pkg::CTRL_WAKE]) begin
            d.wake = 1'b1;
        end

        d.irq = |(stat_vec(q, busy) & q.mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata_o = q.prdata;
    assign pready_o = q.pready;
    assign pslverr_o = q.pslverr;
    assign irq_o = q.irq;
    assign wake_o = q.wake;
    assign link.miso = q.out;
    assign link.miso_oe = q.oe;

endmodule

/* File: scsp_pkg.sv */
// Shared constants for the SPI client serial port and its host end
package scsp_pkg;

    // ------------------------------------------------------------
    // Bus and data widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;

    // ------------------------------------------------------------
    // Client register map
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] C_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] C_STAT = 8'h04;
    localparam logic [ADDR_W-1:0] C_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] C_DATA = 8'h0C;

    localparam int CTRL_W = 10;
    localparam int CTRL_EN = 0;
    localparam int CTRL_MODE = 1;
    localparam int MODE_W = 4;
    localparam int CTRL_CKP = 5;
    localparam int CTRL_CKE = 6;
    localparam int CTRL_SMP = 7;
    localparam int CTRL_BUFFER_OVERWRITE_ENABLE = 8;
    localparam int CTRL_WAKE = 9;
    localparam logic [MODE_W-1:0] MODE_CLIENT_SS = 4'h4;
    localparam logic [MODE_W-1:0] MODE_CLIENT_FREE = 4'h5;

    localparam int ST_W = 5;
    localparam int ST_BF = 0;
    localparam int ST_DONE = 1;
    localparam int ST_WRITE_COLLISION_FLAG = 2;
    localparam int ST_OVF = 3;
    localparam int ST_BUSY = 4;

    // ------------------------------------------------------------
    // Host register map
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] H_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] H_TX = 8'h04;
    localparam logic [ADDR_W-1:0] H_RX = 8'h08;
    localparam logic [ADDR_W-1:0] H_STAT = 8'h0C;

    localparam int HC_W = 16;
    localparam int HC_CKP = 0;
    localparam int HC_CKE = 1;
    localparam int HC_HOLD = 2;
    localparam int HC_HALF = 8;
    localparam int HALF_W = 8;
    localparam int HS_BUSY = 0;
    localparam int HS_DONE = 1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 40;
    localparam int LINK_NS = 320;
    localparam int HALF_CYC = LINK_NS / (2 * CLK_NS);
    localparam logic [HC_W-1:0] HC_RESET = HC_W'(HALF_CYC) << HC_HALF;
    localparam int EDGE_W = 5;
    localparam logic [EDGE_W-1:0] EDGE_LAST = EDGE_W'(2 * BYTE_W - 1);

endpackage

/* File: scsp_if.sv */
// Serial link between the SPI host end and the client end
`timescale 1ns/1ns
interface scsp_if #(
    parameter logic MISO_PULL = 1'b1
);
    logic sck;
    logic ss_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_line;

    // Floating client output reads as the external pull level
    assign miso_line = miso_oe ? miso : MISO_PULL;

    modport client (
        input sck,
        input ss_n,
        input mosi,
        output miso,
        output miso_oe
    );

    modport host (
        output sck,
        output ss_n,
        output mosi,
        input miso_line
    );
endinterface

/* File: scsp_host.sv */
// SPI host end: makes the link clock and select, driven over APB
`timescale 1ns/1ns
module scsp_host (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // APB slave
    input wire logic [scsp_pkg::ADDR_W-1:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [scsp_pkg::DATA_W-1:0] pwdata_i,
    output logic [scsp_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Power
    input wire logic sleep_i,
    // Serial link
    scsp_if.host link
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        H_IDLE,
        H_SEL,
        H_CLK,
        H_DESEL
    } scsp_host_state_type;

    typedef struct packed {
        scsp_host_state_type st;
        logic [scsp_pkg::HALF_W-1:0] div;
        logic [scsp_pkg::EDGE_W-1:0] edge_n;
        logic [scsp_pkg::BYTE_W-1:0] sr;
        logic [scsp_pkg::BYTE_W-1:0] rx;
        logic sck;
        logic ss_n;
        logic out;
        logic [scsp_pkg::HC_W-1:0] ctrl;
        logic done;
        logic pready;
        logic pslverr;
        logic [scsp_pkg::DATA_W-1:0] prdata;
    } scsp_host_reg_type;

    scsp_host_reg_type q;
    scsp_host_reg_type d;

    logic clock_idle_polarity;
    logic cke;
    logic hold;
    logic tick;
    logic last;
    logic [scsp_pkg::HALF_W:0] div_next;
    logic [scsp_pkg::BYTE_W-1:0] shifted;
    logic setup;
    logic wr;
    logic rd_busy;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        clock_idle_polarity = q.ctrl[scsp_pkg::HC_CKP];
        cke = q.ctrl[scsp_pkg::HC_CKE];
        hold = q.ctrl[scsp_pkg::HC_HOLD];
        // Half period of zero behaves as one cycle
        div_next = {1'b0, q.div} + 1'b1;
        tick = div_next >= {1'b0, q.ctrl[scsp_pkg::HC_HALF +: scsp_pkg::HALF_W]};
        last = (q.edge_n == scsp_pkg::EDGE_LAST);
        shifted = {q.sr[scsp_pkg::BYTE_W-2:0], link.miso_line};
        rd_busy = (q.st != H_IDLE);

        setup = psel_i && penable_i && !q.pready;
        wr = psel_i && penable_i && q.pready && pwrite_i;
        d.pready = setup;
        d.pslverr = 1'b0;
        d.prdata = '0;
        if (setup) begin
            case (paddr_i)
                scsp_pkg::H_CTRL: d.prdata = scsp_pkg::DATA_W'(q.ctrl);
                scsp_pkg::H_TX: d.pslverr = pwrite_i && rd_busy;
                scsp_pkg::H_RX: d.prdata = scsp_pkg::DATA_W'(q.rx);
                scsp_pkg::H_STAT: begin
                    d.prdata[scsp_pkg::HS_BUSY] = rd_busy;
                    d.prdata[scsp_pkg::HS_DONE] = q.done;
                end
                default: d.pslverr = 1'b1;
            endcase
        end

        if (wr && paddr_i == scsp_pkg::H_STAT && pwdata_i[scsp_pkg::HS_DONE]) begin
            d.done = 1'b0;
        end

        // Sleep stops the divider and holds the transfer where it is
        if (!sleep_i) begin
            d.div = tick ? '0 : div_next[scsp_pkg::HALF_W-1:0];
            unique case (q.st)
                H_IDLE: begin
                    d.div = '0;
                    d.sck = clock_idle_polarity;
                    d.ss_n = q.ss_n || !hold;
                end
                H_SEL: begin
                    if (tick) begin
                        d.st = H_CLK;
                        d.edge_n = '0;
                    end
                end
                H_CLK: begin
                    if (tick) begin
                        d.sck = !q.sck;
                        d.edge_n = q.edge_n + 1'b1;
                        if (q.edge_n[0] != cke) begin
                            d.sr = shifted;
                        end else if (!last) begin
                            d.out = q.sr[scsp_pkg::BYTE_W-1];
                        end
                        if (last) begin
                            // With edge select set the eighth sample came one edge earlier
                            d.rx = cke ? q.sr : shifted;
                            d.st = H_DESEL;
                        end
                    end
                end
                H_DESEL: begin
                    if (tick) begin
                        d.ss_n = !hold;
                        d.done = 1'b1;
                        d.st = H_IDLE;
                    end
                end
            endcase
        end

        if (wr && paddr_i == scsp_pkg::H_CTRL) begin
            d.ctrl = pwdata_i[scsp_pkg::HC_W-1:0];
        end
        // Writes during a transfer are refused with an error answer
        if (wr && paddr_i == scsp_pkg::H_TX && !rd_busy) begin
            d.sr = pwdata_i[scsp_pkg::BYTE_W-1:0];
            d.out = cke ? pwdata_i[scsp_pkg::BYTE_W-1] : q.out;
            d.ss_n = 1'b0;
            d.div = '0;
            d.st = H_SEL;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.ctrl <= scsp_pkg::HC_RESET;
            q.ss_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign prdata_o = q.prdata;
    assign pready_o = q.pready;
    assign pslverr_o = q.pslverr;
    assign link.sck = q.sck;
    assign link.ss_n = q.ss_n;
    assign link.mosi = q.out;

endmodule

/* File: scsp_link_properties.sv */
// Link-side properties of the SPI host and client pair
`timescale 1ns/1ns
module scsp_link_properties (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Link signals
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    logic sck_q;
    logic [3:0] edges_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------
    // Link clock edges within a frame
    // ------------------------------------------------------------
    // Four bits wrap at one byte, so framed multi-byte runs also end at 0
    always_ff @(posedge clk_i) begin
        sck_q <= sck;
        if (!rst_n_i || ss_n) begin
            edges_q <= 4'h0;
        end else if (sck != sck_q) begin
            edges_q <= edges_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_release_on_deselect: assert property ($rose(ss_n) |-> ##[1:5] !miso_oe)
        else $error("client still drives data after deselect");
    a_idle_no_drive: assert property (ss_n [*5] |-> !miso_oe)
        else $error("client drives data while not selected");
    a_sck_idle_deselect: assert property (ss_n |-> !sck)
        else $error("link clock away from idle while deselected");
    a_select_lead: assert property ($fell(ss_n) |-> !sck [*7])
        else $error("link clock moved too soon after select");
    a_sck_half_period: assert property ($changed(sck) |=> $stable(sck) [*3])
        else $error("link clock half period too short");
    a_mosi_after_edge: assert property ($changed(sck) |=> $stable(mosi) [*3])
        else $error("host data moved between clock edges");
    a_miso_follows_sck: assert property (miso_oe && $past(miso_oe) && $past(miso_oe, 2)
        && $changed(miso) |-> ($past(sck, 2) != $past(sck, 3))
        || ($past(sck, 3) != $past(sck, 4)) || ($past(sck, 4) != $past(sck, 5)))
        else $error("client data moved without a link clock edge");
    a_byte_edge_count: assert property ($rose(ss_n) |-> edges_q == 4'h0)
        else $error("frame did not hold whole bytes of clock edges");
endmodule

/* File: spi_client_serial_port_bench.sv */
// Both ends of the SPI link joined, driven and checked over APB
`timescale 1ns/1ns
module spi_client_serial_port_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel_c = 1'b0, psel_h = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic slp_c = 1'b0, slp_h = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] rdata_c, rdata_h, rd;
    logic ready_c, ready_h, err_c, err_h, irq, wake, er, sck_seen;
    int num_errors = 0;
    int checked = 0;

    always #20 clk = ~clk;

    scsp_if #(.MISO_PULL(1'b1)) scsp_if_inst ();
    scsp_client scsp_client_inst (.clk_i(clk), .rst_n_i(rst_n), .paddr_i(paddr),
        .psel_i(psel_c), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
        .prdata_o(rdata_c), .pready_o(ready_c), .pslverr_o(err_c), .sleep_i(slp_c),
        .irq_o(irq), .wake_o(wake), .link(scsp_if_inst.client));
    scsp_host scsp_host_inst (.clk_i(clk), .rst_n_i(rst_n), .paddr_i(paddr),
        .psel_i(psel_h), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
        .prdata_o(rdata_h), .pready_o(ready_h), .pslverr_o(err_h), .sleep_i(slp_h),
        .link(scsp_if_inst.host));
    scsp_link_properties scsp_link_properties_inst (.clk_i(clk), .rst_n_i(rst_n),
        .sck(scsp_if_inst.sck), .ss_n(scsp_if_inst.ss_n), .mosi(scsp_if_inst.mosi),
        .miso(scsp_if_inst.miso), .miso_oe(scsp_if_inst.miso_oe));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t ns: value mismatch, seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One APB transfer to the host end (h=1) or the client end (h=0)
    task automatic apb(input logic h, input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel_c <= !h;
        psel_h <= h;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while ((h ? ready_h : ready_c) !== 1'b1 && n < 20);
        rd = h ? rdata_h : rdata_c;
        er = h ? err_h : err_c;
        psel_c <= 1'b0;
        psel_h <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            $display("unexpected at %0t ns: no bus answer", $time);
        end
    endtask

    task automatic cw(input logic [7:0] a, input logic [31:0] d);
        apb(1'b0, 1'b1, a, d);
    endtask

    task automatic cr(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, 1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    // Polls the host status until its busy bit reads clear
    task automatic fin;
        int n;
        n = 0;
        do begin
            apb(1'b1, 1'b0, scsp_pkg::H_STAT, 32'h0000_0000);
            n++;
        end while (rd[scsp_pkg::HS_BUSY] !== 1'b0 && n < 200);
        if (rd[scsp_pkg::HS_BUSY] !== 1'b0) begin
            num_errors++;
            $display("unexpected at %0t ns: host byte never finished", $time);
        end
    endtask

    task automatic xfer(input logic [7:0] tx, input logic [7:0] exp_rx);
        apb(1'b1, 1'b1, scsp_pkg::H_TX, {24'h00_0000, tx});
        fin();
        apb(1'b1, 1'b0, scsp_pkg::H_RX, 32'h0000_0000);
        chk(rd, {24'h00_0000, exp_rx});
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        cr(scsp_pkg::C_CTRL, 32'h0000_0000);
        apb(1'b1, 1'b0, scsp_pkg::H_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0400);
        cw(scsp_pkg::C_MASK, 32'h0000_0002);
        cw(scsp_pkg::C_CTRL, 32'h0000_0009);
        cw(scsp_pkg::C_DATA, 32'h0000_00A5);
        xfer(8'h3C, 8'hA5);
        cr(scsp_pkg::C_STAT, 32'h0000_0003);
        chk({31'h0, irq}, 32'h0000_0001);
        cw(scsp_pkg::C_MASK, 32'h0000_0000);
        cr(scsp_pkg::C_DATA, 32'h0000_003C);
        chk({31'h0, irq}, 32'h0000_0000);
        cw(scsp_pkg::C_MASK, 32'h0000_0002);
        cr(scsp_pkg::C_STAT, 32'h0000_0002);
        cw(scsp_pkg::C_STAT, 32'h0000_0002);
        cr(scsp_pkg::C_STAT, 32'h0000_0000);
        apb(1'b0, 1'b0, 8'h10, 32'h0000_0000);
        chk({rd[30:0], er}, 32'h0000_0001);
        $display("test basic exchange done");
        xfer(8'h96, 8'h3C);
        xfer(8'h11, 8'h96);
        cr(scsp_pkg::C_STAT, 32'h0000_000B);
        cr(scsp_pkg::C_DATA, 32'h0000_0096);
        cw(scsp_pkg::C_STAT, 32'h0000_000E);
        cw(scsp_pkg::C_CTRL, 32'h0000_0109);
        xfer(8'h22, 8'h11);
        xfer(8'h33, 8'h22);
        cw(scsp_pkg::C_DATA, 32'h0000_005A);
        xfer(8'h44, 8'h5A);
        cr(scsp_pkg::C_DATA, 32'h0000_0044);
        cw(scsp_pkg::C_STAT, 32'h0000_000E);
        $display("test daisy chain and overflow done");
        // Client write lands mid byte and must collide
        apb(1'b1, 1'b1, scsp_pkg::H_TX, 32'h0000_000F);
        repeat (30) @(posedge clk);
        cw(scsp_pkg::C_DATA, 32'h0000_00FF);
        // Host refuses a new byte in mid frame
        apb(1'b1, 1'b1, scsp_pkg::H_TX, 32'h0000_0077);
        chk({31'h0, er}, 32'h0000_0001);
        fin();
        apb(1'b1, 1'b0, scsp_pkg::H_RX, 32'h0000_0000);
        chk(rd, 32'h0000_0044);
        cr(scsp_pkg::C_STAT, 32'h0000_0007);
        cr(scsp_pkg::C_DATA, 32'h0000_000F);
        cw(scsp_pkg::C_STAT, 32'h0000_000E);
        // Disabling mid byte drops the partial byte
        apb(1'b1, 1'b1, scsp_pkg::H_TX, 32'h0000_00F0);
        repeat (30) @(posedge clk);
        cw(scsp_pkg::C_CTRL, 32'h0000_0000);
        cw(scsp_pkg::C_CTRL, 32'h0000_0009);
        fin();
        cr(scsp_pkg::C_STAT, 32'h0000_0000);
        cw(scsp_pkg::C_DATA, 32'h0000_005A);
        xfer(8'h81, 8'h5A);
        cr(scsp_pkg::C_DATA, 32'h0000_0081);
        cw(scsp_pkg::C_STAT, 32'h0000_000E);
        // Mode code outside both client modes (0100, 0101) leaves the client off
        cw(scsp_pkg::C_CTRL, 32'h0000_000F);
        xfer(8'h55, 8'hFF);
        cr(scsp_pkg::C_STAT, 32'h0000_0000);
        $display("test collision, abort and mode done");
        @(posedge clk) slp_c <= 1'b1;
        cw(scsp_pkg::C_CTRL, 32'h0000_0209);
        xfer(8'h6E, 8'h81);
        chk({31'h0, wake}, 32'h0000_0001);
        @(posedge clk) slp_c <= 1'b0;
        cr(scsp_pkg::C_DATA, 32'h0000_006E);
        chk({31'h0, wake}, 32'h0000_0000);
        // Host asleep mid byte: link frozen, registers still served
        apb(1'b1, 1'b1, scsp_pkg::H_TX, 32'h0000_00C3);
        repeat (20) @(posedge clk);
        slp_h <= 1'b1;
        repeat (4) @(posedge clk);
        sck_seen = scsp_if_inst.sck;
        // One half period apart, so a running clock cannot match by chance
        repeat (10) begin
            repeat (4) @(posedge clk);
            chk({31'h0, scsp_if_inst.sck}, {31'h0, sck_seen});
        end
        apb(1'b1, 1'b0, scsp_pkg::H_STAT, 32'h0000_0000);
        chk({31'h0, rd[scsp_pkg::HS_BUSY]}, 32'h0000_0001);
        slp_h <= 1'b0;
        fin();
        apb(1'b1, 1'b0, scsp_pkg::H_RX, 32'h0000_0000);
        chk(rd, 32'h0000_006E);
        cr(scsp_pkg::C_DATA, 32'h0000_00C3);
        $display("test sleep done");
        cw(scsp_pkg::C_CTRL, 32'h0000_0049);
        apb(1'b1, 1'b1, scsp_pkg::H_CTRL, 32'h0000_0402);
        cw(scsp_pkg::C_DATA, 32'h0000_003A);
        xfer(8'h5E, 8'h3A);
        cr(scsp_pkg::C_DATA, 32'h0000_005E);
        $display("test clock edge select done");
        wrap_up();
    end

    // Whole run needs well under ten thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("unexpected at %0t ns: run did not finish", $time);
        wrap_up();
    end
endmodule
